// ### fwpc_map.svh
// Purpose: offsets, field positions, reset values and counts of the write-protect block
// Assumes: included by its bare name from the package only
// Notes: configuration byte and protect byte keep the documented bit order
`ifndef FWPC_MAP_SVH
`define FWPC_MAP_SVH

// configuration byte fields
`define FWPC_CFG_IOC 1
`define FWPC_CFG_VLP 2
`define FWPC_CFG_SEC 3
`define FWPC_CFG_WSE 4
`define FWPC_CFG_WSP 5
`define FWPC_CFG_SHARED_PIN_FUNCTION_SELECT 6
`define FWPC_CFG_PROTECT_PIN_ENABLE_BIT 7
`define FWPC_CFG_WR_MASK 8'hc2

// protect byte fields (level bits 5:2, lockdown bit 7)
`define FWPC_ST_LVL_LO 2
`define FWPC_ST_LVL_HI 5
`define FWPC_ST_BPL 7

// reset values
`define FWPC_LVL_RESET 4'h7
`define FWPC_BPL_RESET 1'b0

// lower bounds of the protected upper ranges, 19-bit byte address
`define FWPC_ADDR_W 19
`define FWPC_BOUND_EIGHTH 19'h70000
`define FWPC_BOUND_QUARTER 19'h60000
`define FWPC_BOUND_HALF 19'h40000
`define FWPC_BOUND_ALL 19'h00000
`define FWPC_BOUND_NONE 19'h7ffff

// synchroniser depth
`define FWPC_SYNC_STAGES 2

`endif

// ### fwpc_pkg.sv
// Purpose: types shared by the write-protect block and its bench
// Assumes: constants come from fwpc_map.svh
// Notes: command codes are internal and not the serial opcodes
`default_nettype none
package fwpc_pkg;
`include "fwpc_map.svh"

    typedef enum logic [3:0] {
        FWPC_OP_NONE = 4'h0,
        FWPC_OP_WRSR = 4'h1,
        FWPC_OP_LOCK_PROTECTION_SETTINGS_CMD = 4'h2,
        FWPC_OP_SID_LOCK = 4'h3,
        FWPC_OP_SID_PROG = 4'h4,
        FWPC_OP_PROGRAM = 4'h5,
        FWPC_OP_ERASE = 4'h6,
        FWPC_OP_QUAD = 4'h7,
        FWPC_OP_SUSPEND = 4'h8,
        FWPC_OP_RESUME = 4'h9,
        FWPC_OP_SW_RESET = 4'ha
    } fwpc_op_e;

    typedef enum logic [2:0] {
        FWPC_RES_OK = 3'h0,
        FWPC_RES_LOCKED = 3'h1,
        FWPC_RES_INVALID = 3'h2,
        FWPC_RES_PROTECTED = 3'h3,
        FWPC_RES_IGNORED = 3'h4
    } fwpc_res_e;

    typedef enum logic [2:0] {
        FWPC_ST_RESET = 3'b001,
        FWPC_ST_NV_LOAD = 3'b010,
        FWPC_ST_RUN = 3'b100
    } fwpc_state_e;

    typedef struct packed {
        fwpc_op_e op;
        logic four_line;
        logic has_config;
        logic [7:0] status_data;
        logic [7:0] config_data;
        logic [`FWPC_ADDR_W-1:0] addr;
    } fwpc_cmd_s;

    typedef struct packed {
        logic done;
        logic ok;
        fwpc_res_e reason;
    } fwpc_result_s;

    typedef struct packed {
        logic sec;
        logic shared_pin_function_select;
        logic protect_pin_enable_bit;
    } fwpc_nv_s;

    typedef struct packed {
        logic wp_enabled;
        logic rst_enabled;
        logic hold_enabled;
        logic quad_lines;
    } fwpc_pinfunc_s;

endpackage
`default_nettype wire

// ### fwpc_top.sv
// Purpose: protect-level, lockdown and configuration-byte logic of a serial flash
// Assumes: commands arrive decoded on the serial clock, at most one per frame
// Notes: nonvolatile bits live outside; they are loaded after reset and stored on request
`timescale 1ns/10ps
`default_nettype none
module fwpc_top
    import fwpc_pkg::*;
#(
    parameter int ADDR_W = `FWPC_ADDR_W
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sck,
    input wire logic i_cmd_valid,
    input wire fwpc_cmd_s i_cmd,
    input wire logic i_wp_n,
    input wire logic i_rst_pin_n,
    input wire logic i_prog_busy,
    input wire logic i_erase_busy,
    input wire fwpc_nv_s i_nv,
    output logic o_ready,
    output logic [7:0] o_config,
    output logic [7:0] o_protect,
    output logic [ADDR_W-1:0] o_protect_lo,
    output logic o_protect_any,
    output fwpc_result_s o_result,
    output logic o_nv_store,
    output fwpc_nv_s o_nv_data,
    output fwpc_pinfunc_s o_pin_func
);

    // link domain: capture the command and flip a toggle
    fwpc_cmd_s link_cmd;
    logic link_tgl;

    always_ff @(posedge i_sck or negedge i_rstn) begin
        if (!i_rstn) begin
            link_cmd <= '0;
            link_tgl <= 1'b0;
        end else if (i_cmd_valid) begin
            link_cmd <= i_cmd;
            link_tgl <= ~link_tgl;
        end
    end

    // core domain synchronisers; the first stage feeds only the second
    logic tgl_s1, tgl_s2, tgl_s3;
    logic wp_s1, wp_n_s;
    logic rp_s1, rst_pin_n_s;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
            wp_s1 <= 1'b1;
            wp_n_s <= 1'b1;
            rp_s1 <= 1'b1;
            rst_pin_n_s <= 1'b1;
        end else begin
            tgl_s1 <= link_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
            wp_s1 <= i_wp_n;
            wp_n_s <= wp_s1;
            rp_s1 <= i_rst_pin_n;
            rst_pin_n_s <= rp_s1;
        end
    end

    // link_cmd is stable here: it changed at least two core edges before the toggle arrives
    logic cmd_ev;
    fwpc_cmd_s cmd;
    assign cmd_ev = tgl_s2 ^ tgl_s3;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd <= '0;
        end else if (cmd_ev) begin
            cmd <= link_cmd;
        end
    end

    logic cmd_go;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd_go <= 1'b0;
        end else begin
            cmd_go <= cmd_ev;
        end
    end

    // power-up sequence: reset, fetch nonvolatile bits, run
    fwpc_state_e state;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= FWPC_ST_RESET;
        end else begin
            unique case (state)
                FWPC_ST_RESET: begin
                    state <= FWPC_ST_NV_LOAD;
                end
                FWPC_ST_NV_LOAD: begin
                    state <= FWPC_ST_RUN;
                end
                FWPC_ST_RUN: begin
                    state <= FWPC_ST_RUN;
                end
                default: begin
                    state <= FWPC_ST_RESET;
                end
            endcase
        end
    end

    logic run;
    assign run = (state == FWPC_ST_RUN);

    // configuration and protect state
    logic [3:0] lvl;
    logic protection_lockdown_bit, io_pin_reconfig_bit, volatile_lock_bit, sec, shared_pin_function_select, protect_pin_enable_bit, erase_suspended_flag, program_suspended_flag;

    // shared pins become data lines; reset function only when selected
    logic hw_rst;
    assign hw_rst = run & ~rst_pin_n_s & shared_pin_function_select & ~io_pin_reconfig_bit;

    // hardware protection needs pin low, io bit 0, enable 1
    logic hw_prot;
    assign hw_prot = ~wp_n_s & ~io_pin_reconfig_bit & protect_pin_enable_bit;

    // pin high leaves the lockdown bit without effect
    logic lock_eff;
    assign lock_eff = protection_lockdown_bit & hw_prot;

    logic op_wrsr, op_lock_protection_settings_cmd, op_sid_lock, op_sid_prog, op_prog, op_erase;
    logic op_quad, op_susp, op_resume, op_swrst;
    assign op_wrsr = cmd_go & run & (cmd.op == FWPC_OP_WRSR);
    assign op_lock_protection_settings_cmd = cmd_go & run & (cmd.op == FWPC_OP_LOCK_PROTECTION_SETTINGS_CMD);
    assign op_sid_lock = cmd_go & run & (cmd.op == FWPC_OP_SID_LOCK);
    assign op_sid_prog = cmd_go & run & (cmd.op == FWPC_OP_SID_PROG);
    assign op_prog = cmd_go & run & (cmd.op == FWPC_OP_PROGRAM);
    assign op_erase = cmd_go & run & (cmd.op == FWPC_OP_ERASE);
    assign op_quad = cmd_go & run & (cmd.op == FWPC_OP_QUAD);
    assign op_susp = cmd_go & run & (cmd.op == FWPC_OP_SUSPEND);
    assign op_resume = cmd_go & run & (cmd.op == FWPC_OP_RESUME);
    assign op_swrst = cmd_go & run & (cmd.op == FWPC_OP_SW_RESET);

    // level bits move only when not locked down and not volatile-locked
    logic lvl_wr_ok;
    assign lvl_wr_ok = ~lock_eff & ~volatile_lock_bit;

    logic [3:0] wr_lvl;
    logic wr_bpl;
    assign wr_lvl = cmd.status_data[`FWPC_ST_LVL_HI:`FWPC_ST_LVL_LO];
    assign wr_bpl = cmd.status_data[`FWPC_ST_BPL];

    // while hardware-locked WRSR leaves the configuration byte unchanged as well
    logic cfg_wr;
    assign cfg_wr = op_wrsr & cmd.has_config & ~lock_eff;

    // decode of the level bits; the top bit is ignored
    function automatic logic [ADDR_W-1:0] lvl_bound(input logic [3:0] l);
        logic [ADDR_W-1:0] b;
        b = ADDR_W'(`FWPC_BOUND_NONE);
        if (l[2]) begin
            b = ADDR_W'(`FWPC_BOUND_ALL);
        end else begin
            unique case (l[1:0])
                2'h1: b = ADDR_W'(`FWPC_BOUND_EIGHTH);
                2'h2: b = ADDR_W'(`FWPC_BOUND_QUARTER);
                2'h3: b = ADDR_W'(`FWPC_BOUND_HALF);
                default: b = ADDR_W'(`FWPC_BOUND_NONE);
            endcase
        end
        return b;
    endfunction

    function automatic logic lvl_any(input logic [3:0] l);
        return (l[2:0] != 3'h0);
    endfunction

    // program or erase target inside the protected range
    logic hit;
    assign hit = lvl_any(lvl) & (cmd.addr >= lvl_bound(lvl));

    // quad commands valid in four-line protocol or with io bit set
    logic quad_ok;
    assign quad_ok = cmd.four_line | io_pin_reconfig_bit;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lvl <= `FWPC_LVL_RESET;
            protection_lockdown_bit <= `FWPC_BPL_RESET;
        end else if (hw_rst) begin
            lvl <= `FWPC_LVL_RESET;
            protection_lockdown_bit <= `FWPC_BPL_RESET;
        end else if (op_wrsr && !lock_eff) begin
            // lockdown ignores writes only while the pin protects; it arms only under hardware protection
            protection_lockdown_bit <= wr_bpl & hw_prot;
            if (lvl_wr_ok) begin
                lvl <= wr_lvl;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            io_pin_reconfig_bit <= 1'b0;
        end else if (hw_rst || op_swrst) begin
            io_pin_reconfig_bit <= 1'b0;
        end else if (cfg_wr) begin
            io_pin_reconfig_bit <= cmd.config_data[`FWPC_CFG_IOC];
        end
    end

    // volatile lock; software reset and writes leave it alone
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            volatile_lock_bit <= 1'b0;
        end else if (hw_rst) begin
            volatile_lock_bit <= 1'b0;
        end else if (op_lock_protection_settings_cmd) begin
            volatile_lock_bit <= 1'b1;
        end
    end

    // nonvolatile bits fetched after power-up; pin and software resets leave them alone
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sec <= 1'b0;
            shared_pin_function_select <= 1'b0;
            protect_pin_enable_bit <= 1'b0;
        end else if (state == FWPC_ST_NV_LOAD) begin
            sec <= i_nv.sec;
            shared_pin_function_select <= i_nv.shared_pin_function_select;
            protect_pin_enable_bit <= i_nv.protect_pin_enable_bit;
        end else begin
            if (op_sid_lock) begin
                sec <= 1'b1;
            end
            if (cfg_wr) begin
                shared_pin_function_select <= cmd.config_data[`FWPC_CFG_SHARED_PIN_FUNCTION_SELECT];
                protect_pin_enable_bit <= cmd.config_data[`FWPC_CFG_PROTECT_PIN_ENABLE_BIT];
            end
        end
    end

    // suspend flags follow suspend and resume, reset clears them
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            erase_suspended_flag <= 1'b0;
            program_suspended_flag <= 1'b0;
        end else if (hw_rst || op_swrst) begin
            erase_suspended_flag <= 1'b0;
            program_suspended_flag <= 1'b0;
        end else if (op_susp) begin
            if (i_prog_busy) begin
                program_suspended_flag <= 1'b1;
            end else if (i_erase_busy) begin
                erase_suspended_flag <= 1'b1;
            end
        end else if (op_resume) begin
            // a program suspended inside a suspended erase resumes first
            if (program_suspended_flag) begin
                program_suspended_flag <= 1'b0;
            end else begin
                erase_suspended_flag <= 1'b0;
            end
        end
    end

    // command outcome, one pulse per command
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_result <= '0;
        end else begin
            o_result <= '0;
            if (cmd_go) begin
                o_result.done <= 1'b1;
                o_result.ok <= 1'b1;
                o_result.reason <= FWPC_RES_OK;
                if (!run || hw_rst) begin
                    o_result.ok <= 1'b0;
                    o_result.reason <= FWPC_RES_IGNORED;
                end else if (op_wrsr && (lock_eff || (volatile_lock_bit && wr_lvl != lvl))) begin
                    o_result.ok <= 1'b0;
                    o_result.reason <= FWPC_RES_LOCKED;
                end else if (op_sid_prog && sec) begin
                    // secure space is read-only once locked
                    o_result.ok <= 1'b0;
                    o_result.reason <= FWPC_RES_LOCKED;
                end else if (op_quad && !quad_ok) begin
                    // quad command without io bit in single-line mode
                    o_result.ok <= 1'b0;
                    o_result.reason <= FWPC_RES_INVALID;
                end else if ((op_prog || op_erase) && hit) begin
                    o_result.ok <= 1'b0;
                    o_result.reason <= FWPC_RES_PROTECTED;
                end
            end
        end
    end

    // request to the nonvolatile store on every secure-id lock or configuration write
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_nv_store <= 1'b0;
            o_nv_data <= '0;
        end else begin
            o_nv_store <= op_sid_lock | cfg_wr;
            o_nv_data.sec <= sec | op_sid_lock;
            o_nv_data.shared_pin_function_select <= cfg_wr ? cmd.config_data[`FWPC_CFG_SHARED_PIN_FUNCTION_SELECT] : shared_pin_function_select;
            o_nv_data.protect_pin_enable_bit <= cfg_wr ? cmd.config_data[`FWPC_CFG_PROTECT_PIN_ENABLE_BIT] : protect_pin_enable_bit;
        end
    end

    // visible registers; bits 1:0 and bit 6 of the protect byte read zero
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_config <= 8'h00;
            o_protect <= 8'h00;
            o_protect_lo <= ADDR_W'(`FWPC_BOUND_NONE);
            o_protect_any <= 1'b0;
            o_ready <= 1'b0;
        end else begin
            o_config <= {protect_pin_enable_bit, shared_pin_function_select, program_suspended_flag, erase_suspended_flag, sec, volatile_lock_bit, io_pin_reconfig_bit, 1'b0};
            o_protect <= {protection_lockdown_bit, 1'b0, lvl, 2'h0};
            // decoded range for the array engine
            o_protect_lo <= lvl_bound(lvl);
            o_protect_any <= lvl_any(lvl);
            o_ready <= run;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pin_func <= '0;
        end else begin
            o_pin_func.quad_lines <= io_pin_reconfig_bit;
            o_pin_func.wp_enabled <= ~io_pin_reconfig_bit & protect_pin_enable_bit;
            o_pin_func.rst_enabled <= ~io_pin_reconfig_bit & shared_pin_function_select;
            o_pin_func.hold_enabled <= ~io_pin_reconfig_bit & ~shared_pin_function_select;
        end
    end

endmodule
`default_nettype wire

// ### fwpc_top_assertions.sv
// Purpose: port-level checks of the write-protect block
// Assumes: one command in flight at a time, pins steady around commands
// Notes: the last command is captured on the link clock to qualify results
`timescale 1ns/10ps
`default_nettype none
module fwpc_top_assertions
    import fwpc_pkg::*;
#(
    parameter int ADDR_W = 19
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sck,
    input wire logic i_cmd_valid,
    input wire fwpc_cmd_s i_cmd,
    input wire logic i_wp_n,
    input wire logic i_rst_pin_n,
    input wire logic i_prog_busy,
    input wire logic o_ready,
    input wire logic [7:0] o_config,
    input wire logic [7:0] o_protect,
    input wire logic [ADDR_W-1:0] o_protect_lo,
    input wire logic o_protect_any,
    input wire fwpc_result_s o_result
);
    fwpc_cmd_s last_cmd;
    logic [5:0] pin_hist;
    logic [5:0] wp_hist;
    logic [ADDR_W-1:0] lo_exp;
    logic done;
    logic quiet;

    always_ff @(posedge i_sck or negedge i_rstn) begin
        if (!i_rstn) begin
            last_cmd <= '0;
        end else if (i_cmd_valid) begin
            last_cmd <= i_cmd;
        end
    end

    // histories start pessimistic so nothing fires just after reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_hist <= '0;
            wp_hist <= '1;
        end else begin
            pin_hist <= {pin_hist[4:0], i_rst_pin_n};
            wp_hist <= {wp_hist[4:0], i_wp_n};
        end
    end

    always_comb begin
        case (o_protect[4:2])
            3'h0: lo_exp = 19'h7ffff;
            3'h1: lo_exp = 19'h70000;
            3'h2: lo_exp = 19'h60000;
            3'h3: lo_exp = 19'h40000;
            default: lo_exp = 19'h00000;
        endcase
    end

    assign quiet = &pin_hist;
    assign done = o_result.done && o_ready && quiet;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    AST_READY_LEVEL: assert property ($rose(o_ready) |-> o_protect == 8'h1c)
        else $error("protect byte wrong at ready");
    AST_DECODE: assert property ((o_protect == $past(o_protect)) &&
        (o_protect == $past(o_protect, 2)) |->
        o_protect_lo == lo_exp && o_protect_any == (o_protect[4:2] != 3'h0))
        else $error("protected range does not match level");
    AST_HW_PIN: assert property ((!i_rst_pin_n && o_config[6] && !o_config[1]) [*6] |->
        o_protect == 8'h1c && o_config[2:1] == 2'h0 && o_config[5:4] == 2'h0)
        else $error("reset pin did not clear state");
    AST_VLP_HOLD: assert property (o_config[2] && quiet |=> o_config[2])
        else $error("volatile lock dropped without reset");
    AST_SEC_HOLD: assert property (o_config[3] |=> o_config[3])
        else $error("secure id flag dropped");
    AST_CFG_RSVD: assert property (o_config[0] == 1'b0)
        else $error("reserved config bit set");
    AST_QUAD_INV: assert property (done && last_cmd.op == FWPC_OP_QUAD &&
        !last_cmd.four_line && !o_config[1] |-> o_result.reason == FWPC_RES_INVALID)
        else $error("quad command accepted without io bit");
    AST_PROT: assert property (done && (last_cmd.op == FWPC_OP_PROGRAM ||
        last_cmd.op == FWPC_OP_ERASE) && o_protect_any && last_cmd.addr >= o_protect_lo
        |-> o_result.reason == FWPC_RES_PROTECTED)
        else $error("write into protected range accepted");
    AST_LOCK_PROTECTION_SETTINGS_CMD: assert property (done && last_cmd.op == FWPC_OP_LOCK_PROTECTION_SETTINGS_CMD && o_result.ok
        |-> ##[1:2] o_config[2])
        else $error("lock command did not set volatile lock");
    AST_VLP_FREEZE: assert property (done && last_cmd.op == FWPC_OP_WRSR && o_config[2]
        |=> $stable(o_protect[5:2]) [*2])
        else $error("level changed under volatile lock");
    AST_BPL_ARM: assert property ($rose(o_protect[7]) |->
        o_config[7] && !o_config[1] && wp_hist == 6'h00)
        else $error("lockdown armed without pin protection");
    AST_SUSP_PROG: assert property (done && last_cmd.op == FWPC_OP_SUSPEND && i_prog_busy
        |-> ##[1:2] o_config[5])
        else $error("program suspend flag not set");

    CV_LOCKDOWN: cover property ($rose(o_protect[7]));
    CV_QUAD: cover property (done && last_cmd.op == FWPC_OP_QUAD);
    CV_PIN_RESET: cover property ($fell(o_config[2]));
endmodule

bind fwpc_top fwpc_top_assertions #(.ADDR_W(ADDR_W)) chk_u (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_sck(i_sck), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_wp_n(i_wp_n),
    .i_rst_pin_n(i_rst_pin_n), .i_prog_busy(i_prog_busy), .o_ready(o_ready),
    .o_config(o_config), .o_protect(o_protect), .o_protect_lo(o_protect_lo),
    .o_protect_any(o_protect_any), .o_result(o_result));
`default_nettype wire

// ### fwpc_host_model.sv
// Purpose: host side of the command link
// Assumes: caller waits for the answer before the next frame
// Notes: sck idles low; command lines carry junk outside the taken edge
`timescale 1ns/10ps
`default_nettype none
module fwpc_host_model
    import fwpc_pkg::*;
(
    output var logic o_sck,
    output var logic o_cmd_valid,
    output var fwpc_cmd_s o_cmd
);
    initial begin
        o_sck = 1'b0;
        o_cmd_valid = 1'b0;
        o_cmd = '1;
    end

    // four sck periods per frame; the command is taken on the second rise
    task automatic send(input fwpc_cmd_s c);
        #7;
        for (int k = 0; k < 4; k++) begin
            if (k == 1) begin
                o_cmd <= c;
                o_cmd_valid <= 1'b1;
            end
            #15 o_sck = 1'b1;
            if (k == 1) begin
                o_cmd_valid <= 1'b0;
                o_cmd <= ~c;
            end
            #15 o_sck = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: self-checking bench of the write-protect block
// Assumes: commands one at a time through the host model
// Notes: nonvolatile bits come straight from nv, never stored back
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import fwpc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wp_n = 1'b1;
    logic rst_pin_n = 1'b1;
    logic prog_busy = 1'b0;
    logic erase_busy = 1'b0;
    fwpc_nv_s nv = 3'b011;
    logic sck;
    logic cmd_valid;
    fwpc_cmd_s cmd;
    logic ready;
    logic [7:0] cfg;
    logic [7:0] prot;
    logic [18:0] lo;
    logic any;
    fwpc_result_s res;
    fwpc_pinfunc_s pins;
    logic nv_st;
    fwpc_nv_s nv_dat;
    fwpc_nv_s nv_seen = 3'b000;
    int fails = 0;
    int num_checks = 0;
    logic [3:0] lvl;
    logic [18:0] ex_lo;

    always #12.5 clk = ~clk;

    fwpc_host_model host_u (.o_sck(sck), .o_cmd_valid(cmd_valid), .o_cmd(cmd));
    fwpc_top dut_u (.i_clk(clk), .i_rstn(rstn), .i_sck(sck), .i_cmd_valid(cmd_valid),
        .i_cmd(cmd), .i_wp_n(wp_n), .i_rst_pin_n(rst_pin_n), .i_prog_busy(prog_busy),
        .i_erase_busy(erase_busy), .i_nv(nv), .o_ready(ready), .o_config(cfg),
        .o_protect(prot), .o_protect_lo(lo), .o_protect_any(any), .o_result(res),
        .o_nv_store(nv_st), .o_nv_data(nv_dat), .o_pin_func(pins));

    // keep the last store request so the retained bits can be compared later
    always @(posedge clk) begin
        if (nv_st === 1'b1) begin
            nv_seen <= nv_dat;
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask

    task automatic give_verdict;
        if (fails == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // config byte travels only when nonzero
    task automatic do_cmd(input fwpc_op_e op, input logic [7:0] sd, input logic [7:0] cd,
            input logic fl, input logic [18:0] ad, input fwpc_res_e er);
        int i;
        host_u.send('{op, fl, cd != 8'h00, sd, cd, ad});
        for (i = 0; i < 40 && res.done !== 1'b1; i++) begin
            @(negedge clk);
        end
        chk("done", res.done, 1'b1);
        chk("reason", res.reason, er);
        cycles(3);
    endtask

    task automatic run(input fwpc_op_e op, input fwpc_res_e er);
        do_cmd(op, 8'h00, 8'h00, 1'b0, 19'h0, er);
    endtask

    task automatic wrsr(input logic [7:0] sd, input logic [7:0] cd, input fwpc_res_e er);
        do_cmd(FWPC_OP_WRSR, sd, cd, 1'b0, 19'h0, er);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        cycles(6);
        chk("protect", prot, 8'h1c);
        chk("config", cfg, 8'hc0);
        // all level codes, the last with the ignored top bit set
        for (int k = 0; k < 9; k++) begin
            lvl = (k == 8) ? 4'h9 : k[3:0];
            ex_lo = lvl[2] ? 19'h00000 : (lvl[1:0] == 2'h1) ? 19'h70000 :
                (lvl[1:0] == 2'h2) ? 19'h60000 : (lvl[1:0] == 2'h3) ? 19'h40000 : 19'h7ffff;
            wrsr({2'h0, lvl, 2'h0}, 8'h00, FWPC_RES_OK);
            chk("lo", lo, ex_lo);
            chk("any", any, lvl[2:0] != 3'h0);
            do_cmd(FWPC_OP_ERASE, 8'h00, 8'h00, 1'b0, 19'h70000,
                (lvl[2:0] != 3'h0) ? FWPC_RES_PROTECTED : FWPC_RES_OK);
            do_cmd(FWPC_OP_PROGRAM, 8'h00, 8'h00, 1'b0, 19'h3ffff,
                lvl[2] ? FWPC_RES_PROTECTED : FWPC_RES_OK);
        end
        run(FWPC_OP_QUAD, FWPC_RES_INVALID);
        do_cmd(FWPC_OP_QUAD, 8'h00, 8'h00, 1'b1, 19'h0, FWPC_RES_OK);
        wrsr(8'h00, 8'hff, FWPC_RES_OK);
        chk("config", cfg, 8'hc2);
        chk("nv_store", nv_seen, 3'b011);
        chk("pins", pins, 4'h1);
        run(FWPC_OP_QUAD, FWPC_RES_OK);
        run(FWPC_OP_SW_RESET, FWPC_RES_OK);
        chk("config", cfg, 8'hc0);
        chk("pins", pins, 4'hc);
        @(posedge clk) wp_n <= 1'b0;
        cycles(4);
        wrsr(8'h8c, 8'h00, FWPC_RES_OK);
        chk("protect", prot, 8'h8c);
        wrsr(8'h00, 8'h00, FWPC_RES_LOCKED);
        chk("protect", prot, 8'h8c);
        @(posedge clk) wp_n <= 1'b1;
        cycles(4);
        wrsr(8'h84, 8'h00, FWPC_RES_OK);
        chk("protect", prot, 8'h04);
        run(FWPC_OP_LOCK_PROTECTION_SETTINGS_CMD, FWPC_RES_OK);
        chk("vlp", cfg[2], 1'b1);
        wrsr(8'h08, 8'h00, FWPC_RES_LOCKED);
        run(FWPC_OP_SW_RESET, FWPC_RES_OK);
        chk("vlp", cfg[2], 1'b1);
        chk("protect", prot, 8'h04);
        @(posedge clk) rst_pin_n <= 1'b0;
        cycles(8);
        chk("protect", prot, 8'h1c);
        chk("vlp", cfg[2], 1'b0);
        @(posedge clk) rst_pin_n <= 1'b1;
        cycles(6);
        run(FWPC_OP_SID_PROG, FWPC_RES_OK);
        run(FWPC_OP_SID_LOCK, FWPC_RES_OK);
        chk("sec", cfg[3], 1'b1);
        chk("nv_store", nv_seen, 3'b111);
        run(FWPC_OP_SID_PROG, FWPC_RES_LOCKED);
        @(posedge clk) prog_busy <= 1'b1;
        run(FWPC_OP_SUSPEND, FWPC_RES_OK);
        chk("suspend", cfg[5:4], 2'h2);
        run(FWPC_OP_RESUME, FWPC_RES_OK);
        chk("suspend", cfg[5:4], 2'h0);
        @(posedge clk) {prog_busy, erase_busy} <= 2'b01;
        run(FWPC_OP_SUSPEND, FWPC_RES_OK);
        chk("suspend", cfg[5:4], 2'h1);
        run(FWPC_OP_RESUME, FWPC_RES_OK);
        chk("suspend", cfg[5:4], 2'h0);
        @(posedge clk) nv <= 3'b111;
        @(posedge clk) rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        cycles(6);
        chk("config", cfg, 8'hc8);
        chk("protect", prot, 8'h1c);
        give_verdict();
    end

    // the sequence needs about five hundred cycles; this allows some forty times that
    initial begin
        #500000;
        fails++;
        give_verdict();
    end
endmodule
`default_nettype wire
